// *** core/cds_steer.sv ***
/*
  CPU-owned data steering between the 32-bit local bus, the 16-bit slot
  bus, the 8-bit on-chip I/O bus and the BIOS ROM. A request is split into
  narrow accesses queued in a FIFO; an issuer runs them on the slot/ROM
  side and assembles reads before answering. Assumes the requester holds
  req until done, slot/ROM acknowledge each access with acc_done, and that
  pins are resolved outside (oe low = driving).
*/
//
// Behaviour
// - local lanes 0..3 are data bits 7-0, 15-8, 23-16, 31-24.
// - slot bus low half is bits 7-0, high half bits 15-8.
// - 8-bit slot writes send each enabled lane to slot low, one access per byte.
// - on-chip 8-bit I/O writes use the same byte-serial steering.
// - 16-bit slot byte write: even lanes to low half, odd lanes to high.
// - 16-bit slot word writes: lane pairs to both halves, one access per pair.
// - DRAM, local bus device and flash writes leave all pads three-stated.
// - DRAM and wide local device reads leave all pads three-stated.
// - 8-bit slot reads put slot low onto each requested lane, byte-serial.
// - slot read data is latched, then driven onto local lanes.
// - on-chip I/O reads take internal data, drive lane and both slot halves.
// - 16-bit slot byte read delivers slot low onto the addressed lane.
// - 16-bit slot word reads: slot halves to lanes 0,1 or 2,3 per access.
// - 8-bit ROM reads copy lane 2 onto each addressed lane, byte-serial.
// - 16-bit ROM byte read copies lane 2 or 3 onto the addressed lane.
// - 16-bit ROM word reads copy lanes 2,3 onto lanes 0,1 or 2,3.
// - DRAM, local device and flash cycles bypass steering entirely.
`timescale 1ns/1ps
`default_nettype none
`include "cds_defs.svh"
module cds_steer (
  input wire logic clk, // system clock, 100 MHz
  input wire logic rstn, // sync reset, active low
  input wire logic req_valid, // cpu cycle request, held until done
  input wire cds_pkg::cds_req_s req, // cycle attributes and write data
  output logic req_done, // one-cycle pulse: cycle complete
  output logic [31:0] rdata, // assembled read data, valid with req_done
  output logic [31:0] local_out, // local lanes drive value
  output logic [3:0] local_oe_n, // per lane enable, low drives
  input wire logic [31:0] local_in, // local lanes pin level
  output logic [15:0] slot_out, // slot halves drive value
  output logic [1:0] slot_oe_n, // bit0 low half, bit1 high half, low drives
  input wire logic [15:0] slot_in, // slot halves pin level
  input wire logic [7:0] iobus_in, // on-chip i/o read data, same clock
  output logic [7:0] iobus_out, // on-chip i/o write data
  output logic acc_start, // one-cycle pulse: narrow access begins
  output logic [1:0] acc_lane, // addressed lane of this access
  output logic acc_wide, // access uses both halves / lane pair
  input wire logic acc_done // narrow access finished (pin domain)
);
  typedef enum {ST_IDLE, ST_SPLIT, ST_ISSUE, ST_WAIT, ST_DRIVE} cds_st_e;
  cds_st_e state_reg;
  cds_pkg::cds_req_s cur_reg;
  logic [3:0] left_reg;
  // each lane owns its own byte flop; the word is only wired together
  wire logic [31:0] asm_word;
  logic [1:0] done_sync_reg;
  logic done_seen_reg;
  logic done_rise;
  logic steered;
  logic byte_serial;
  logic lane_serial16;
  cds_pkg::cds_acc_s acc_in;
  cds_pkg::cds_acc_s acc_head;
  cds_pkg::cds_acc_s acc_reg;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [1:0] pick_lane;
  logic pick_wide;
  logic [3:0] pick_mask;

  // acc_done comes from the pin side: two flops before use
  always_ff @(posedge clk) begin
    if (!rstn) begin
      done_sync_reg <= 2'h0;
      done_seen_reg <= 1'b0;
    end else begin
      done_sync_reg <= {done_sync_reg[0], acc_done};
      done_seen_reg <= done_sync_reg[1];
    end
  end
  assign done_rise = done_sync_reg[1] && !done_seen_reg;

  // only slot, i/o bus and rom targets pass through the steering paths
  always_comb begin
    steered = 1'b1;
    byte_serial = 1'b0;
    lane_serial16 = 1'b0;
    case (req.target)
      cds_pkg::CDS_T_SLOT8, cds_pkg::CDS_T_IOBUS8, cds_pkg::CDS_T_ROM8:
        byte_serial = 1'b1;
      cds_pkg::CDS_T_SLOT16, cds_pkg::CDS_T_ROM16:
        lane_serial16 = 1'b1;
      default:
        steered = 1'b0;
    endcase
  end

  // next narrow access from remaining enables: lowest lane first
  always_comb begin
    pick_lane = 2'h0;
    pick_wide = 1'b0;
    pick_mask = 4'h0;
    if (left_reg[0] || left_reg[1]) begin
      pick_lane = left_reg[0] ? 2'h0 : 2'h1;
    end else begin
      pick_lane = left_reg[2] ? 2'h2 : 2'h3;
    end
    if (cur_reg.target == cds_pkg::CDS_T_SLOT16 || cur_reg.target == cds_pkg::CDS_T_ROM16) begin
      // a lane pair is one access, so aligned word = 1, dword or split word = 2
      pick_wide = pick_lane[1] ? (left_reg[2] && left_reg[3]) : (left_reg[0] && left_reg[1]);
      pick_mask = pick_lane[1] ? (left_reg & 4'hC) : (left_reg & 4'h3);
    end else begin
      pick_mask = 4'h1 << pick_lane; // one access per byte
    end
  end

  assign acc_in = '{lane: pick_lane, wide: pick_wide, data: 16'h0000};
  assign fifo_in_valid = (state_reg == ST_SPLIT) && (left_reg != 4'h0);
  assign fifo_out_ready = (state_reg == ST_ISSUE);

  cds_fifo #(.WIDTH($bits(cds_pkg::cds_acc_s)), .DEPTH(`CDS_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(acc_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(acc_head)
  );

  // sequencer: split, issue one access at a time, then answer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      cur_reg <= '0;
      left_reg <= 4'h0;
      acc_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (req_valid && steered && !req_done) begin
            cur_reg <= req;
            left_reg <= req.byte_en;
            state_reg <= ST_SPLIT;
          end
        end
        ST_SPLIT: begin
          if (left_reg == 4'h0) begin
            state_reg <= ST_ISSUE;
          end else if (fifo_in_ready) begin
            left_reg <= left_reg & ~pick_mask;
          end
        end
        ST_ISSUE: begin
          if (fifo_out_valid) begin
            acc_reg <= acc_head;
            state_reg <= ST_WAIT;
          end else begin
            state_reg <= ST_DRIVE;
          end
        end
        ST_WAIT: begin
          if (done_rise) begin
            state_reg <= ST_ISSUE;
          end
        end
        ST_DRIVE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_start <= 1'b0;
      acc_lane <= 2'h0;
      acc_wide <= 1'b0;
    end else begin
      acc_start <= (state_reg == ST_ISSUE) && fifo_out_valid;
      if ((state_reg == ST_ISSUE) && fifo_out_valid) begin
        acc_lane <= acc_head.lane;
        acc_wide <= acc_head.wide;
      end
    end
  end

  // read capture per lane into the assembly latch
  genvar g;
  generate
    for (g = 0; g < `CDS_LANES; g++) begin : g_lane
      logic hit;
      logic [7:0] src;
      logic [7:0] byte_reg;
      // lane g holds data bits 8g+7..8g
      assign hit = (acc_reg.lane == 2'(g)) || (acc_reg.wide && (acc_reg.lane[1] == 1'(g / 2)));
      always_comb begin
        src = 8'h00;
        case (cur_reg.target)
          cds_pkg::CDS_T_IOBUS8: src = iobus_in;
          cds_pkg::CDS_T_ROM8: src = local_in[23:16];
          cds_pkg::CDS_T_ROM16: src = (g % 2 == 1) ? local_in[31:24] : local_in[23:16];
          cds_pkg::CDS_T_SLOT16: src = (g % 2 == 1 && acc_reg.wide) ? slot_in[15:8] :
                                       slot_in[7:0];
          default: src = slot_in[7:0];
        endcase
      end
      always_ff @(posedge clk) begin
        if (!rstn) begin
          byte_reg <= 8'h00;
        end else if (state_reg == ST_WAIT && done_rise && !cur_reg.write && hit) begin
          byte_reg <= src;
        end
      end
      assign asm_word[8*g +: 8] = byte_reg;
    end
  endgenerate

  // pads: write data to slot, read data redriven only after assembly
  always_ff @(posedge clk) begin
    if (!rstn) begin
      local_out <= 32'h0000_0000;
      local_oe_n <= 4'hF;
      slot_out <= 16'h0000;
      slot_oe_n <= 2'h3;
      iobus_out <= 8'h00;
      req_done <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      req_done <= (state_reg == ST_DRIVE);
      local_oe_n <= 4'hF; // three-state outside steered phases
      slot_oe_n <= 2'h3;
      if (state_reg == ST_WAIT && cur_reg.write) begin
        if (cur_reg.target == cds_pkg::CDS_T_SLOT16 && (acc_reg.wide || acc_reg.lane[0])) begin
          slot_out <= acc_reg.lane[1] ? cur_reg.wdata[31:16] : cur_reg.wdata[15:0];
          slot_oe_n <= acc_reg.wide ? 2'h0 : 2'h1; // odd byte on high half
        end else if (cur_reg.target == cds_pkg::CDS_T_SLOT16) begin
          slot_out <= {8'h00, cur_reg.wdata[8*acc_reg.lane +: 8]};
          slot_oe_n <= 2'h2; // even byte on low half
        end else begin
          slot_out <= {8'h00, cur_reg.wdata[8*acc_reg.lane +: 8]};
          slot_oe_n <= 2'h2;
          iobus_out <= cur_reg.wdata[8*acc_reg.lane +: 8];
        end
      end
      if (state_reg == ST_DRIVE && !cur_reg.write) begin
        local_out <= asm_word;
        local_oe_n <= ~cur_reg.byte_en;
        rdata <= asm_word;
        if (cur_reg.target == cds_pkg::CDS_T_IOBUS8) begin
          slot_out <= {iobus_in, iobus_in};
          slot_oe_n <= 2'h0;
        end
      end
    end
  end

  a_done_after_drive: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == ST_DRIVE) |=> req_done) else $error("done missing");
  a_dram_pads_off: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == ST_IDLE && !req_done) |=> (local_oe_n == 4'hF))
    else $error("local pads driven while idle");
  a_read_slot_off: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == ST_WAIT && !cur_reg.write) |=> (slot_oe_n == 2'h3))
    else $error("slot driven during read");
  a_bypass_idle: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == ST_IDLE && req_valid && !steered) |=> state_reg == ST_IDLE)
    else $error("bypass target steered");
  a_wide_only16: assert property (@(posedge clk) disable iff (!rstn)
    acc_start && acc_wide |-> cur_reg.target inside {cds_pkg::CDS_T_SLOT16,
    cds_pkg::CDS_T_ROM16}) else $error("wide access on 8-bit target");
  a_slot8_low: assert property (@(posedge clk) disable iff (!rstn)
    $past(state_reg == ST_WAIT && cur_reg.write && cur_reg.target == cds_pkg::CDS_T_SLOT8)
    |-> slot_oe_n == 2'h2) else $error("8-bit write off low half");
  a_io_both_halves: assert property (@(posedge clk) disable iff (!rstn)
    $past(state_reg == ST_DRIVE && !cur_reg.write && cur_reg.target == cds_pkg::CDS_T_IOBUS8)
    |-> slot_oe_n == 2'h0 && req_done) else $error("io read halves off");
  a_rdata_latched: assert property (@(posedge clk) disable iff (!rstn)
    req_done && !cur_reg.write |-> rdata == local_out)
    else $error("read data not redriven");
endmodule // cds_steer
`default_nettype wire

// *** core/cds_defs.svh ***
/*
  Constants for the data steering block: lane count, FIFO depth
  and pad timing. Assumes inclusion by bare name from core/ sources.
*/
`ifndef CDS_DEFS_SVH
`define CDS_DEFS_SVH
`define CDS_LANES 4
`define CDS_FIFO_DEPTH 8
`define CDS_PHASE_CYCLES 2'h1
`endif

// *** core/cds_pkg.sv ***
/*
  Types for the data steering block: target kinds and request carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cds_pkg;
  typedef enum logic [2:0] {
    CDS_T_SLOT8, CDS_T_SLOT16, CDS_T_IOBUS8, CDS_T_ROM8, CDS_T_ROM16,
    CDS_T_DRAM, CDS_T_WIDE_LOCAL, CDS_T_FLASH
  } cds_target_e;
  typedef struct packed {
    logic write;
    cds_target_e target;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cds_req_s;
  typedef struct packed {
    logic [1:0] lane;
    logic wide;
    logic [15:0] data;
  } cds_acc_s;
endpackage

// *** core/cds_fifo.sv ***
/*
  Parameterised valid/ready FIFO holding the narrow slot accesses.
  Assumes single clock clk with synchronous active-low reset rstn.
*/
`timescale 1ns/1ps
`default_nettype none
module cds_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rstn, // sync reset, active low
  input wire logic in_valid, // write side valid
  output logic in_ready, // not full
  input wire logic [WIDTH-1:0] in_data, // entry in
  output logic out_valid, // not empty
  input wire logic out_ready, // reader takes entry
  output logic [WIDTH-1:0] out_data // head entry
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // cds_fifo
`default_nettype wire

// *** testbench/cds_slot_model.sv ***
/* Partner model of the slot, ROM and on-chip bus side of the steering block.
   Assumes acc_start pulses and a level acc_done handshake on clk. */
`timescale 1ns/1ps
`default_nettype none
module cds_slot_model (
  input wire logic clk, // system clock
  input wire logic acc_start, // access begins
  input wire logic [1:0] acc_lane, // addressed lane
  input wire logic [15:0] slot_out, // slot drive value
  input wire logic [1:0] slot_oe_n, // slot enables, low drives
  input wire logic [7:0] iobus_out, // on-chip write byte
  input wire logic [15:0] base, // read data seed
  input wire logic slow, // long access when high
  output logic acc_done, // access finished
  output logic [15:0] slot_in, // slot pins
  output logic [31:0] local_in, // local pins, rom data on lanes 2 and 3
  output logic [7:0] iobus_in, // on-chip read data
  output logic wr_seen, // one pulse per access
  output logic [25:0] wr_obs // slot oe_n, slot value, on-chip byte
);
  logic on;
  logic [15:0] drv;
  logic [4:0] cnt;
  logic [4:0] dly;
  // released lines show the inverse, so stale data never passes for fresh
  assign slot_in = on ? drv : ~drv;
  assign local_in = {slot_in, ~drv};
  assign iobus_in = slot_in[7:0];
  assign dly = slow ? 5'h0c : 5'h01;
  initial begin
    acc_done = 1'b0;
    wr_seen = 1'b0;
    on = 1'b0;
    drv = 16'h0000;
    cnt = 5'h00;
    wr_obs = {2'b11, 24'h00_0000};
  end
  always @(posedge clk) begin
    wr_seen <= 1'b0;
    if (acc_start) begin
      cnt <= 5'h01;
      drv <= {base[15:8] + 8'(8'h11 * acc_lane), base[7:0] + 8'(8'h11 * acc_lane)};
      on <= 1'b1;
      wr_obs <= {2'b11, 24'h00_0000};
    end else if (cnt != 5'h00) begin
      cnt <= cnt + 5'h01;
      if (slot_oe_n != 2'b11) wr_obs[25:8] <= {slot_oe_n, slot_out};
      if (cnt == dly) begin
        acc_done <= 1'b1;
        wr_obs[7:0] <= iobus_out;
      end
      if (cnt == dly + 5'h01) wr_seen <= 1'b1;
      if (cnt == dly + 5'h02) acc_done <= 1'b0;
      // data held well past the design's synchroniser and latch
      if (cnt == dly + 5'h06) begin
        on <= 1'b0;
        cnt <= 5'h00;
      end
    end
  end
endmodule // cds_slot_model
`default_nettype wire

// *** testbench/cpu_data_steering_bench.sv ***
/* Self-checking bench for cds_steer with the slot and rom partner model.
   Assumes one 100 MHz clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module cpu_data_steering_bench;
  logic clk, rstn, req_valid, req_done, acc_start, acc_wide, acc_done, slow, wr_seen;
  cds_pkg::cds_req_s req;
  logic [31:0] rdata, local_out, local_in, lfsr;
  logic [3:0] local_oe_n;
  logic [15:0] slot_out, slot_in, base;
  logic [1:0] slot_oe_n, acc_lane;
  logic [7:0] iobus_in, iobus_out;
  logic [25:0] wr_obs;
  int n_mismatch, cmp_count, nacc;
  logic [69:0] exp_rd[$];
  logic [26:0] exp_wr[$];
  logic [3:0] sw[4] = '{4'hf, 4'h6, 4'h2, 4'h4};
  logic [3:0] sr[4] = '{4'hf, 4'h3, 4'h6, 4'h8};
  logic [3:0] rr[4] = '{4'hf, 4'h6, 4'h8, 4'h1};
  cds_steer u_cds_steer (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .req_done(req_done), .rdata(rdata), .local_out(local_out), .local_oe_n(local_oe_n),
    .local_in(local_in), .slot_out(slot_out), .slot_oe_n(slot_oe_n), .slot_in(slot_in),
    .iobus_in(iobus_in), .iobus_out(iobus_out), .acc_start(acc_start),
    .acc_lane(acc_lane), .acc_wide(acc_wide), .acc_done(acc_done));
  cds_slot_model u_cds_slot_model (.clk(clk), .acc_start(acc_start), .acc_lane(acc_lane),
    .slot_out(slot_out), .slot_oe_n(slot_oe_n), .iobus_out(iobus_out), .base(base),
    .slow(slow), .acc_done(acc_done), .slot_in(slot_in), .local_in(local_in),
    .iobus_in(iobus_in), .wr_seen(wr_seen), .wr_obs(wr_obs));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one request: note what must come back, then hold it until done
  task automatic run(input logic w, input cds_pkg::cds_target_e t, input logic [3:0] be);
    logic [31:0] d, m, e;
    logic [15:0] b;
    logic [7:0] k;
    int c, n, l;
    lfsr = nxt(lfsr);
    d = lfsr;
    b = d[15:0] ^ 16'ha5c3;
    if (be == 4'h0) be = (d[7:4] == 4'h0) ? 4'h8 : d[7:4];
    m = 32'h0000_0000;
    e = 32'h0000_0000;
    c = 0;
    for (int i = 0; i < 4; i++) if (be[i]) m[8*i+:8] = 8'hff;
    if (t == cds_pkg::CDS_T_SLOT16 || t == cds_pkg::CDS_T_ROM16) begin
      for (int p = 0; p < 2; p++) if (be[2*p+:2] != 2'b00) begin
        c++;
        l = be[2*p] ? 2 * p : 2 * p + 1;
        k = 8'(8'h11 * l);
        // a lone byte of a 16-bit slot arrives on the low half, whichever lane
        if (t == cds_pkg::CDS_T_SLOT16 && be[2*p+:2] != 2'b11) e[16*p+:16] = {2{b[7:0] + k}};
        else e[16*p+:16] = {b[15:8] + k, b[7:0] + k};
        if (w) exp_wr.push_back({~be[2*p+1], ~be[2*p], d[16*p+:16] & m[16*p+:16], 9'h000});
      end
    end else begin
      for (int i = 0; i < 4; i++) if (be[i]) begin
        c++;
        e[8*i+:8] = b[7:0] + 8'(8'h11 * i);
        if (w && t == cds_pkg::CDS_T_IOBUS8) exp_wr.push_back({18'h3_0000, d[8*i+:8], 1'b1});
        else if (w) exp_wr.push_back({2'b10, 8'h00, d[8*i+:8], 9'h000});
      end
    end
    exp_rd.push_back({t == cds_pkg::CDS_T_IOBUS8, w, 4'(c), m, e & m});
    @(posedge clk);
    base <= b;
    slow <= d[4];
    req <= '{w, t, be, d};
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_done !== 1'b1 && n < 3000);
    req_valid <= 1'b0;
    if (n >= 3000) chk("req_done wait", 32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic off_test(input cds_pkg::cds_target_e t, input logic w);
    @(posedge clk);
    req <= '{w, t, 4'hf, lfsr};
    req_valid <= 1'b1;
    repeat (20) begin
      @(posedge clk);
      chk("pads off", 32'h0000_007e, {local_oe_n, slot_oe_n, acc_start});
    end
    req_valid <= 1'b0;
  endtask
  // result watcher: every write access and every completion takes the oldest note
  always @(posedge clk) begin
    logic [69:0] y;
    logic [26:0] x;
    logic [17:0] v;
    nacc <= req_done ? 0 : nacc + int'(acc_start);
    if (wr_seen && req.write) begin
      if (exp_wr.size() == 0) chk("stray access", 32'h0000_0000, 32'h0000_0001);
      else begin
        x = exp_wr.pop_front();
        v = {wr_obs[25:24], wr_obs[23:8] & {{8{~wr_obs[25]}}, {8{~wr_obs[24]}}}};
        if (x[0]) chk("iobus_out", x[8:1], wr_obs[7:0]);
        else chk("slot drive", x[26:9], v);
      end
    end
    if (req_done === 1'b1) begin
      if (exp_rd.size() == 0) chk("stray done", 32'h0000_0000, 32'h0000_0001);
      else begin
        y = exp_rd.pop_front();
        chk("access count", y[67:64], nacc);
        if (!y[68]) begin
          chk("rdata", y[31:0], rdata & y[63:32]);
          chk("local_out", y[31:0], local_out & y[63:32]);
          chk("local_oe_n", {~y[56], ~y[48], ~y[40], ~y[32]}, local_oe_n);
          if (y[69]) chk("slot_oe_n", 32'h0000_0000, slot_oe_n);
        end
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    base = 16'h0000;
    slow = 1'b0;
    lfsr = 32'hef3b_5046;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    chk("reset pads", 32'h0000_007e, {local_oe_n, slot_oe_n, req_done});
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      run(i[0], cds_pkg::CDS_T_SLOT8, (i < 2) ? 4'hf : 4'h0);
      run(i[0], cds_pkg::CDS_T_IOBUS8, (i < 2) ? 4'hf : 4'h0);
      run(1'b0, cds_pkg::CDS_T_ROM8, (i < 2) ? 4'hf : 4'h0);
    end
    $display("test byte serial done");
    for (int i = 0; i < 4; i++) begin
      run(1'b1, cds_pkg::CDS_T_SLOT16, sw[i]);
      run(1'b0, cds_pkg::CDS_T_SLOT16, sr[i]);
      run(1'b0, cds_pkg::CDS_T_ROM16, rr[i]);
    end
    $display("test sixteen bit done");
    for (int w = 0; w < 2; w++) begin
      off_test(cds_pkg::CDS_T_DRAM, w[0]);
      off_test(cds_pkg::CDS_T_WIDE_LOCAL, w[0]);
      off_test(cds_pkg::CDS_T_FLASH, w[0]);
    end
    $display("test direct targets done");
    repeat (20) @(posedge clk);
    chk("notes left", 32'h0000_0000, exp_rd.size() + exp_wr.size());
    finish_test();
  end
endmodule // cpu_data_steering_bench
`default_nettype wire
